// *** rtl/sar_conversion_sequencer.v ***
// Operation
// - a select falling edge ends acquisition and starts a conversion.
// - a conversion opens both ground switches, then takes both arrays off the inputs.
// - the sixteen elements are tried one at a time, msb first.
// - each trial adds one binary-weighted element to those already kept on the reference.
// - after the search the device reacquires and forms the output code.
// - the device runs up to 100 kSPS and powers down between conversions.
// - each delivered result belongs to the conversion just made.
// - the output code is straight binary over the input span.
// - an input above the span saturates to all ones.
// - an input below ground saturates to all zeros.
// - the serial output is released while select is high.
// - after the fifth shift-clock fall the output is driven low.
// - result bits then leave msb first, one per later shift-clock fall.

`timescale 1ns/1ns
`default_nettype none

`include "sar_sequencer_map.vh"

module sar_conversion_sequencer (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_select_n,
	input  wire        i_host_shift_clock,
	input  wire        i_comp_above,
	input  wire        i_over_range,
	input  wire        i_under_range,
	output reg         o_pos_array_ground_switch,
	output reg         o_neg_array_ground_switch,
	output reg         o_array_to_inputs,
	output reg  [15:0] o_element_ref,
	output reg         o_powered,
	output reg         o_busy,
	output reg  [15:0] o_result,
	output reg         o_result_valid,
	output reg         o_sdo,
	output reg         o_sdo_oe
);

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
localparam [2:0] ST_ACQ    = 3'h0;
localparam [2:0] ST_OPEN   = 3'h1;
localparam [2:0] ST_HOLD   = 3'h2;
localparam [2:0] ST_TRIAL  = 3'h3;
localparam [2:0] ST_DECIDE = 3'h4;
localparam [2:0] ST_DONE   = 3'h5;

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
reg  [1:0] sel_sync;
reg  [1:0] sck_sync;
reg        sel_prev;
reg        sck_prev;
wire       sel_fall;
wire       sck_fall;

// reset to the idle pin levels so leaving reset makes no false edge
always @(posedge i_clk) begin
	if (i_rst) begin
		sel_sync <= 2'h3;
		sck_sync <= 2'h3;
		sel_prev <= 1'h1;
		sck_prev <= 1'h1;
	end else begin
		sel_sync <= {sel_sync[0], i_select_n};
		sck_sync <= {sck_sync[0], i_host_shift_clock};
		sel_prev <= sel_sync[1];
		sck_prev <= sck_sync[1];
	end
end

assign sel_fall = sel_prev & ~sel_sync[1];
assign sck_fall = sck_prev & ~sck_sync[1];

// ----------------------------------------------------------------
// conversion sequencer
// ----------------------------------------------------------------
reg  [2:0]  state;
reg  [3:0]  bit_idx;
reg  [1:0]  settle;
reg  [15:0] trial;
wire [15:0] one_hot;

// one-hot mask of the element under test
genvar g;
generate
	for (g = 0; g < `SAR_BITS; g = g + 1) begin : gen_onehot
		assign one_hot[g] = (bit_idx == g);
	end
endgenerate

always @(posedge i_clk) begin
	if (i_rst) begin
		state                     <= ST_ACQ;
		bit_idx                   <= 4'hf;
		settle                    <= 2'h0;
		trial                     <= 16'h0000;
		o_pos_array_ground_switch <= 1'h1;
		o_neg_array_ground_switch <= 1'h1;
		o_array_to_inputs         <= 1'h1;
		o_element_ref             <= 16'h0000;
		o_powered                 <= 1'h0;
		o_busy                    <= 1'h0;
		o_result                  <= 16'h0000;
		o_result_valid            <= 1'h0;
	end else begin
		o_result_valid <= 1'h0;
		case (state)
		ST_ACQ: begin
			if (sel_fall) begin
				o_powered                 <= 1'h1;
				o_busy                    <= 1'h1;
				o_pos_array_ground_switch <= 1'h0;
				o_neg_array_ground_switch <= 1'h0;
				state                     <= ST_OPEN;
			end else begin
				// hold the sampling set-up, also after a stray state code
				o_array_to_inputs         <= 1'h1;
				o_pos_array_ground_switch <= 1'h1;
				o_neg_array_ground_switch <= 1'h1;
				o_element_ref             <= 16'h0000;
				o_powered                 <= 1'h0;
				o_busy                    <= 1'h0;
			end
		end
		ST_OPEN: begin
			o_array_to_inputs <= 1'h0;
			o_element_ref     <= 16'h0000;
			bit_idx           <= 4'hf;
			trial             <= 16'h0000;
			state             <= ST_TRIAL;
		end
		ST_TRIAL: begin
			o_element_ref <= trial | one_hot;
			settle        <= 2'h0;
			state         <= ST_HOLD;
		end
		ST_HOLD: begin
			if (settle == `SAR_SETTLE_CYCLES - 1)
				state <= ST_DECIDE;
			else
				settle <= settle + 2'h1;
		end
		ST_DECIDE: begin
			// comparator has settled over the hold cycles
			if (i_comp_above)
				trial <= trial | one_hot;
			if (bit_idx == 4'h0)
				state <= ST_DONE;
			else begin
				bit_idx <= bit_idx - 4'h1;
				state   <= ST_TRIAL;
			end
		end
		ST_DONE: begin
			// saturation codes override the search result
			if (i_over_range)
				o_result <= `SAR_FULL_CODE;
			else if (i_under_range)
				o_result <= `SAR_ZERO_CODE;
			else
				o_result <= trial;
			o_result_valid            <= 1'h1;
			o_array_to_inputs         <= 1'h1;
			o_pos_array_ground_switch <= 1'h1;
			o_neg_array_ground_switch <= 1'h1;
			o_element_ref             <= 16'h0000;
			o_powered                 <= 1'h0;
			o_busy                    <= 1'h0;
			state                     <= ST_ACQ;
		end
		default: state <= ST_ACQ;
		endcase
	end
end

// ----------------------------------------------------------------
// serial output
// ----------------------------------------------------------------
reg  [2:0]  lead_cnt;
reg  [4:0]  shift_cnt;
reg  [15:0] shift_reg;

// shift-clock falls are counted only while select is low
always @(posedge i_clk) begin
	if (i_rst) begin
		lead_cnt  <= 3'h0;
		shift_cnt <= 5'h00;
		shift_reg <= 16'h0000;
		o_sdo     <= 1'h0;
		o_sdo_oe  <= 1'h0;
	end else if (sel_sync[1]) begin
		// line released; no stale word survives into the next frame
		lead_cnt  <= 3'h0;
		shift_cnt <= 5'h00;
		shift_reg <= 16'h0000;
		o_sdo     <= 1'h0;
		o_sdo_oe  <= 1'h0;
	end else begin
		if (o_result_valid)
			shift_reg <= o_result;
		if (sck_fall) begin
			// the first falls only count; the fifth turns the driver on
			if (lead_cnt < `SAR_LEAD_EDGES) begin
				lead_cnt <= lead_cnt + 3'h1;
				if (lead_cnt == `SAR_LEAD_EDGES - 1) begin
					o_sdo_oe <= 1'h1;
					o_sdo    <= 1'h0;
				end
			end else if (shift_cnt < `SAR_BITS) begin
				o_sdo     <= shift_reg[`SAR_MSB];
				shift_reg <= {shift_reg[14:0], 1'h0};
				shift_cnt <= shift_cnt + 5'h01;
			end else
				o_sdo <= 1'h0;
		end
	end
end

endmodule
`default_nettype wire

// *** rtl/sar_sequencer_map.vh ***
`ifndef SAR_SEQUENCER_MAP_VH
`define SAR_SEQUENCER_MAP_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define SAR_BITS          16
`define SAR_MSB           15
`define SAR_ZERO_CODE     16'h0000
`define SAR_FULL_CODE     16'hffff
`define SAR_MID_CODE      16'h8000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SAR_CLK_MHZ       50
`define SAR_RATE_KSPS     100
`define SAR_FRAME_CYCLES  ((`SAR_CLK_MHZ * 1000) / `SAR_RATE_KSPS)
`define SAR_SETTLE_CYCLES 2
`define SAR_LEAD_EDGES    5

`endif

// *** verif/sar_seq_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module sar_seq_chk (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_select_n,
	input wire logic        o_pos_array_ground_switch,
	input wire logic        o_neg_array_ground_switch,
	input wire logic        o_array_to_inputs,
	input wire logic [15:0] o_element_ref,
	input wire logic        o_powered,
	input wire logic        o_busy,
	input wire logic        o_result_valid,
	input wire logic        o_sdo,
	input wire logic        o_sdo_oe
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
property p_start; $fell(i_select_n) && !o_busy |-> ##[1:4] o_busy;
endproperty
a_start: assert property (p_start) else $error("start");
property p_hiz; i_select_n[*5] |-> !o_sdo_oe; endproperty
a_hiz: assert property (p_hiz) else $error("hiz");
property p_open; $rose(o_busy) |-> o_powered &&
	!o_pos_array_ground_switch && !o_neg_array_ground_switch &&
	o_array_to_inputs ##1 !o_array_to_inputs;
endproperty
a_open: assert property (p_open) else $error("open");
property p_msb; $fell(o_array_to_inputs) |=> o_element_ref == 16'h8000;
endproperty
a_msb: assert property (p_msb) else $error("msb");
property p_step;
	o_busy |-> $countones(o_element_ref ^ $past(o_element_ref)) <= 2;
endproperty
a_step: assert property (p_step) else $error("step");
property p_span; $rose(o_busy) |-> ##[60:75] o_result_valid; endproperty
a_span: assert property (p_span) else $error("span");
property p_pulse; o_result_valid |=> !o_result_valid; endproperty
a_pulse: assert property (p_pulse) else $error("pulse");
property p_idle; o_result_valid |->
	##[0:2] (!o_powered && o_pos_array_ground_switch); endproperty
a_idle: assert property (p_idle) else $error("idle");
property p_lead; $rose(o_sdo_oe) |-> !o_sdo; endproperty
a_lead: assert property (p_lead) else $error("lead");
cover property (o_result_valid);
cover property ($rose(o_sdo_oe));
cover property (o_element_ref == 16'hffff);
endmodule
`default_nettype wire

// *** verif/host_reader.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_reader (
	input wire logic  i_clk,
	input wire logic  i_sdo,
	input wire logic  i_sdo_oe,
	output var logic  o_select_n,
	output var logic  o_shift_clock
);
// a released data line reads inverted so a missing enable shows up
wire logic        line;
assign line = i_sdo_oe ? i_sdo : ~i_sdo;
initial begin
	o_select_n = 1'h1;
	o_shift_clock = 1'h1;
end
// shift clock stands high outside frames; 160 ns period inside
task automatic read_frame(output logic [15:0] word, output logic lead);
	logic quiet;
	word = 16'h0000;
	lead = 1'h0;
	quiet = 1'h0;
	@(negedge i_clk) o_select_n = 1'h0;
	repeat (100) @(negedge i_clk);
	for (int n = 1; n <= 21; n++) begin
		o_shift_clock = 1'h0;
		repeat (4) @(negedge i_clk);
		o_shift_clock = 1'h1;
		repeat (4) @(negedge i_clk);
		if (n == 4) quiet = (i_sdo_oe === 1'h0);
		if (n == 5) lead = quiet && (i_sdo_oe === 1'h1) && (line === 1'h0);
		if (n > 5) word = {word[14:0], line};
	end
	o_select_n = 1'h1;
endtask
endmodule
`default_nettype wire

// *** verif/test_sar_conversion_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR %0t %h %h", $time, (a), (b)); end end
module test_sar_conversion_sequencer;
logic        i_clk = 1'h0;
logic        i_rst = 1'h1;
logic        over  = 1'h0;
logic        under = 1'h0;
logic        comp  = 1'h0;
logic        lead;
logic [15:0] level = 16'h0000;
logic [15:0] word;
wire  [15:0] ref_v;
wire  [15:0] res;
wire         sel_n;
wire         sck;
wire         sdo;
wire         oe;
wire         pwr;
int          fail_count = 0;
int          tests_run  = 0;
initial forever #10 i_clk = ~i_clk;
// comparator model: at or above the trial level, updated off the edge
always @(negedge i_clk) comp <= (level >= ref_v);
sar_conversion_sequencer dut_u (.i_clk(i_clk), .i_rst(i_rst),
	.i_select_n(sel_n), .i_host_shift_clock(sck),
	.i_comp_above(comp), .i_over_range(over),
	.i_under_range(under), .o_pos_array_ground_switch(),
	.o_neg_array_ground_switch(), .o_array_to_inputs(),
	.o_element_ref(ref_v), .o_powered(pwr), .o_busy(), .o_result(res),
	.o_result_valid(), .o_sdo(sdo), .o_sdo_oe(oe));
host_reader host_u (.i_clk(i_clk), .i_sdo(sdo), .i_sdo_oe(oe),
	.o_select_n(sel_n), .o_shift_clock(sck));
task final_report;
	$display("mismatches %0d of %0d checks", fail_count, tests_run);
	if (fail_count == 0 && tests_run > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask
task conv(input logic [15:0] lv, input logic o, u, input logic [15:0] e);
	@(negedge i_clk);
	level = lv;
	over = o;
	under = u;
	host_u.read_frame(word, lead);
	`CHK(word, e)
	`CHK(res, e)
	`CHK(lead, 1'h1)
	`CHK(pwr, 1'h0)
	repeat (6) @(negedge i_clk);
	`CHK(oe, 1'h0)
endtask
task t_codes;
	logic [15:0] lv [6];
	lv = '{16'h0000, 16'h0001, 16'h7fff, 16'h8000, 16'hffff, 16'ha5c3};
	foreach (lv[k]) conv(lv[k], 1'h0, 1'h0, lv[k]);
endtask
task t_saturate;
	conv(16'h1234, 1'h1, 1'h0, 16'hffff);
	conv(16'h1234, 1'h0, 1'h1, 16'h0000);
	conv(16'h4321, 1'h1, 1'h1, 16'hffff);
endtask
initial begin
	#1000000;
	fail_count++;
	final_report;
end
initial begin
	repeat (8) @(negedge i_clk);
	i_rst = 1'h0;
	repeat (4) @(negedge i_clk);
	t_codes;
	t_saturate;
	final_report;
end
endmodule
bind sar_conversion_sequencer sar_seq_chk chk_u (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_select_n(i_select_n),
	.o_pos_array_ground_switch(o_pos_array_ground_switch),
	.o_neg_array_ground_switch(o_neg_array_ground_switch),
	.o_array_to_inputs(o_array_to_inputs),
	.o_element_ref(o_element_ref),
	.o_powered(o_powered),
	.o_busy(o_busy),
	.o_result_valid(o_result_valid),
	.o_sdo(o_sdo),
	.o_sdo_oe(o_sdo_oe)
);
`default_nettype wire
